// >>> rtl/siack_cfg.svh
// Function
// - external pending flag follows the priority level inputs, old level cleared
// - acknowledge of a level no longer pending returns the spurious vector
// - external level stays pending until the priority level inputs change
// - up to four sources per level; programmed priority picks the acknowledged one
// - external source with autovector bit clear gets an external acknowledge cycle
// - external acknowledge drives type lines and upper address high, level, low bits 0
// - access type attribute asserts and negates together with the start strobe
// - external autovector source: vector made inside, no external cycle
// - watchdog interrupt answered from the watchdog vector register, no bus cycle
// - internal source, autovector clear: internal acknowledge, peripheral gives vector
// - internal source, autovector set: internal acknowledge, autovector made inside
// - base pointer written only in supervisor mode by control move code C0F
// - watchdog vector register is 8-bit write-only, reset to 0F
// - service pair 55 then AA accepted only in that order
// - any activity between the two service writes is allowed
// - service register is 8-bit write-only, contents not initialised
// - pin assignment register is 8-bit read-write, cleared at reset
// - pin assignment bits select between shared pin functions
// - top pin assignment bit: 0 reset out, 1 second uart request to send
`ifndef SIACK_CFG_SVH
`define SIACK_CFG_SVH

`define SIACK_OFF_WDVEC   10'h042
`define SIACK_OFF_SVC     10'h043
`define SIACK_OFF_PINSEL  10'h0CE
`define SIACK_OFF_PEND    10'h0D0
`define SIACK_OFF_ICR0    10'h0D4
`define SIACK_OFF_EXTAV   10'h0D8
`define SIACK_BASE_CODE   12'hC0F
`define SIACK_WDVEC_RST   8'h0F
`define SIACK_PINSEL_RST  8'h00
`define SIACK_SVC_FIRST   8'h55
`define SIACK_SVC_SECOND  8'hAA
`define SIACK_SPUR_VEC    8'h18
`define SIACK_AUTOVEC_BASE 8'h18
`define SIACK_WDT_LEVEL   3'h7
`define SIACK_WDT_PRIO    2'h3
`define SIACK_ICR_AUTOVECTOR_SELECT_BIT    7
`define SIACK_PIN_RSTSEL  7
`define SIACK_EXT_ADDR_HI 23'h7F_FFFF
`define SIACK_EXT_TT      2'h3

`endif

// >>> rtl/siack_pkg.sv
package siack_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_EXT_TS, ST_EXT_WAIT, ST_INT_ACK, ST_DONE} siack_state_type;
  typedef enum logic [2:0] {RSP_SPUR, RSP_WDT, RSP_INT_VEC, RSP_INT_AUTO,
                            RSP_EXT_BUS, RSP_EXT_AUTO} siack_rsp_type;
  typedef struct packed {
    logic       autovector_select_bit;
    logic [2:0] level;
    logic [1:0] prio;
  } siack_icr_type;
  typedef struct packed {
    siack_state_type    st;
    logic [2:0]         lvl;
    siack_rsp_type      rsp;
    logic [1:0]         idx;
    logic [7:0]         vec;
    logic [31:0]        base;
    logic [7:0]         wdvec;
    logic [7:0]         pinsel;
    siack_icr_type [3:0] interrupt_control_reg;
    logic [7:0]         ext_autovector_select_bit;
    logic [7:0]         pend;
    logic [7:0]         rdata;
    logic               reset_out_signal_pin;
  } siack_top_state_type;

  function automatic logic [7:0] siack_lvl_dec(input logic [2:0] lvl);
    siack_lvl_dec = 8'h01 << lvl;
  endfunction
endpackage

// >>> rtl/siack_core_if.sv
`timescale 1ns/100ps
interface siack_core_if;
  import siack_pkg::*;
  logic [2:0]          ack_level;
  logic [3:0]          int_req;
  siack_icr_type [3:0] interrupt_control_reg;
  logic [7:0]          ext_pend;
  logic [7:0]          ext_autovector_select_bit;
  logic                wdt_req;
  siack_rsp_type       rsp;
  logic [1:0]          idx;
  logic                svc_wr;
  logic [7:0]          svc_data;
  logic                svc_restart;
  modport arb (input ack_level, int_req, interrupt_control_reg, ext_pend, ext_autovector_select_bit, wdt_req,
               output rsp, idx);
  modport svc (input svc_wr, svc_data, output svc_restart);
  modport top (output ack_level, int_req, interrupt_control_reg, ext_pend, ext_autovector_select_bit, wdt_req,
               svc_wr, svc_data, input rsp, idx, svc_restart);
endinterface

// >>> rtl/siack_arb.sv
`timescale 1ns/100ps
`include "siack_cfg.svh"
module siack_arb
  import siack_pkg::*;
(
  siack_core_if.arb s
);
  logic       found;
  logic       is_wdt;
  logic [1:0] best_prio;
  logic [1:0] best_idx;

  // highest programmed priority on the acknowledged level wins
  always_comb begin
    found     = 1'b0;
    is_wdt    = 1'b0;
    best_prio = 2'h0;
    best_idx  = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (s.int_req[i] && s.interrupt_control_reg[i].level == s.ack_level &&
          (!found || s.interrupt_control_reg[i].prio > best_prio)) begin
        found     = 1'b1;
        best_prio = s.interrupt_control_reg[i].prio;
        best_idx  = 2'(i);
      end
    end
    if (s.wdt_req && s.ack_level == `SIACK_WDT_LEVEL &&
        (!found || `SIACK_WDT_PRIO > best_prio)) begin
      found  = 1'b1;
      is_wdt = 1'b1;
    end
    s.idx = best_idx;
    if (found && is_wdt)
      s.rsp = RSP_WDT;
    else if (found)
      s.rsp = s.interrupt_control_reg[best_idx].autovector_select_bit ? RSP_INT_AUTO : RSP_INT_VEC;
    else if (s.ext_pend[s.ack_level])
      s.rsp = s.ext_autovector_select_bit[s.ack_level] ? RSP_EXT_AUTO : RSP_EXT_BUS;
    else
      s.rsp = RSP_SPUR;
  end
endmodule // siack_arb

// >>> rtl/siack_wdsvc.sv
`timescale 1ns/100ps
`include "siack_cfg.svh"
module siack_wdsvc
  import siack_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  siack_core_if.svc s
);
  typedef struct packed {
    logic armed;
    logic restart;
  } siack_svc_type;
  siack_svc_type c_d;
  siack_svc_type c_q;

  // data is never stored; only the sequence position matters
  always_comb begin
    c_d         = c_q;
    c_d.restart = 1'b0;
    if (s.svc_wr) begin
      if (s.svc_data == `SIACK_SVC_FIRST)
        c_d.armed = 1'b1;
      else if (s.svc_data == `SIACK_SVC_SECOND && c_q.armed) begin
        c_d.armed   = 1'b0;
        c_d.restart = 1'b1;
      end
      // other values leave the arm untouched so interleaved writes do no harm
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  assign s.svc_restart = c_q.restart;

  a_svc_order: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(c_q.restart) |-> $past(s.svc_wr) && $past(s.svc_data) == `SIACK_SVC_SECOND
                          && $past(c_q.armed))
    else $error("watchdog restart without ordered pair");
  a_svc_other: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    s.svc_wr && s.svc_data != `SIACK_SVC_SECOND |=> !c_q.restart)
    else $error("watchdog restart from wrong value");
endmodule // siack_wdsvc

// >>> rtl/siack_top.sv
`timescale 1ns/100ps
`include "siack_cfg.svh"
module siack_top
  import siack_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ctl_move_wr,
  input  wire logic [11:0] i_ctl_code,
  input  wire logic        i_supervisor,
  input  wire logic [31:0] i_ctl_wdata,
  input  wire logic        i_acc_valid,
  input  wire logic        i_acc_write,
  input  wire logic [31:0] i_acc_addr,
  input  wire logic [7:0]  i_acc_wdata,
  output logic             o_acc_hit,
  output logic [7:0]       o_acc_rdata,
  input  wire logic [2:0]  i_ipl_n,
  input  wire logic [3:0]  i_int_req,
  input  wire logic [7:0]  i_int_vector,
  input  wire logic        i_wdt_irq,
  input  wire logic        i_iack_req,
  input  wire logic [2:0]  i_iack_level,
  output logic             o_iack_busy,
  output logic             o_iack_done,
  output logic [7:0]       o_iack_vector,
  output logic [3:0]       o_int_iack,
  output logic [27:0]      o_addr,
  output logic [1:0]       o_tt,
  output logic             o_ts_n,
  output logic             o_atm,
  output logic             o_bus_oe,
  input  wire logic        i_ta_n,
  input  wire logic [31:0] i_data,
  output logic             o_wdt_restart,
  output logic [7:0]       o_pin_func,
  input  wire logic        i_reset_out,
  input  wire logic        i_uart2_rts,
  output logic             o_reset_out_signal_rts_pin
);
  siack_core_if        cif ();
  siack_top_state_type s_d;
  siack_top_state_type s_q;
  logic                hit;
  logic [9:0]          off;
  logic                wr;
  logic [7:0]          idx_dec;

  siack_arb siack_arb_inst (
    .s (cif.arb)
  );

  siack_wdsvc siack_wdsvc_inst (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .s         (cif.svc)
  );

  // registers live in a 1 kbyte window above the base pointer; bit 0 marks it valid
  assign hit = i_acc_valid && s_q.base[0] && i_acc_addr[31:10] == s_q.base[31:10];
  assign off = i_acc_addr[9:0];
  assign wr  = hit && i_acc_write;

  assign cif.ack_level = (s_q.st == ST_IDLE) ? i_iack_level : s_q.lvl;
  assign cif.int_req   = i_int_req;
  assign cif.interrupt_control_reg       = s_q.interrupt_control_reg;
  assign cif.ext_pend  = s_q.pend;
  assign cif.ext_autovector_select_bit  = s_q.ext_autovector_select_bit;
  assign cif.wdt_req   = i_wdt_irq;
  assign cif.svc_wr    = wr && off == `SIACK_OFF_SVC;
  assign cif.svc_data  = i_acc_wdata;

  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    // pending tracks the inputs every cycle, so a changed level drops the old one
    s_d.pend     = siack_lvl_dec(~i_ipl_n) & 8'hFE;
    s_d.reset_out_signal_pin = s_q.pinsel[`SIACK_PIN_RSTSEL] ? i_uart2_rts : i_reset_out;
    if (i_ctl_move_wr && i_supervisor && i_ctl_code == `SIACK_BASE_CODE)
      s_d.base = i_ctl_wdata;
    if (wr) begin
      if (off == `SIACK_OFF_WDVEC)
        s_d.wdvec = i_acc_wdata;
      else if (off == `SIACK_OFF_PINSEL)
        s_d.pinsel = i_acc_wdata;
      else if (off == `SIACK_OFF_EXTAV)
        s_d.ext_autovector_select_bit = i_acc_wdata;
      else if (off[9:2] == 8'(`SIACK_OFF_ICR0 >> 2))
        s_d.interrupt_control_reg[off[1:0]] = {i_acc_wdata[`SIACK_ICR_AUTOVECTOR_SELECT_BIT], i_acc_wdata[4:0]};
    end else if (hit) begin
      // write-only locations and unmapped offsets read as zero
      if (off == `SIACK_OFF_PINSEL)
        s_d.rdata = s_q.pinsel;
      else if (off == `SIACK_OFF_PEND)
        s_d.rdata = s_q.pend;
      else if (off == `SIACK_OFF_EXTAV)
        s_d.rdata = s_q.ext_autovector_select_bit;
      else if (off[9:2] == 8'(`SIACK_OFF_ICR0 >> 2))
        s_d.rdata = {s_q.interrupt_control_reg[off[1:0]].autovector_select_bit, 2'b00, s_q.interrupt_control_reg[off[1:0]].level,
                     s_q.interrupt_control_reg[off[1:0]].prio};
    end
    case (s_q.st)
      ST_IDLE: begin
        if (i_iack_req) begin
          s_d.lvl = i_iack_level;
          s_d.rsp = cif.rsp;
          s_d.idx = cif.idx;
          case (cif.rsp)
            RSP_EXT_BUS: s_d.st = ST_EXT_TS;
            RSP_INT_VEC, RSP_INT_AUTO: s_d.st = ST_INT_ACK;
            RSP_WDT: begin
              s_d.vec = s_q.wdvec;
              s_d.st  = ST_DONE;
            end
            RSP_EXT_AUTO: begin
              s_d.vec = `SIACK_AUTOVEC_BASE + {5'h00, i_iack_level};
              s_d.st  = ST_DONE;
            end
            default: begin
              s_d.vec = `SIACK_SPUR_VEC;
              s_d.st  = ST_DONE;
            end
          endcase
        end
      end
      ST_EXT_TS: s_d.st = ST_EXT_WAIT;
      ST_EXT_WAIT: begin
        if (!i_ta_n) begin
          s_d.vec = i_data[31:24];
          s_d.st  = ST_DONE;
        end
      end
      ST_INT_ACK: begin
        if (s_q.rsp == RSP_INT_AUTO)
          s_d.vec = `SIACK_AUTOVEC_BASE + {5'h00, s_q.lvl};
        else
          s_d.vec = i_int_vector;
        s_d.st = ST_DONE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      s_q        <= '0;
      s_q.wdvec  <= `SIACK_WDVEC_RST;
      s_q.pinsel <= `SIACK_PINSEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // bus signals decode straight from the state flop, no logic between
  always_comb begin
    o_ts_n   = !(s_q.st == ST_EXT_TS);
    o_atm    = s_q.st == ST_EXT_TS;
    o_bus_oe = s_q.st == ST_EXT_TS || s_q.st == ST_EXT_WAIT;
    o_tt     = o_bus_oe ? `SIACK_EXT_TT : 2'h0;
    o_addr   = o_bus_oe ? {`SIACK_EXT_ADDR_HI, s_q.lvl, 2'b00} : 28'h000_0000;
  end

  // a function result cannot be part-selected, so the decode goes through a net
  assign idx_dec        = siack_lvl_dec({1'b0, s_q.idx});
  assign o_int_iack     = (s_q.st == ST_INT_ACK) ? idx_dec[3:0] : 4'h0;
  assign o_iack_busy    = s_q.st != ST_IDLE;
  assign o_iack_done    = s_q.st == ST_DONE;
  assign o_iack_vector  = s_q.vec;
  assign o_acc_hit      = hit;
  assign o_acc_rdata    = s_q.rdata;
  assign o_pin_func     = s_q.pinsel;
  assign o_reset_out_signal_rts_pin = s_q.reset_out_signal_pin;
  assign o_wdt_restart  = cif.svc_restart;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_take(siack_rsp_type r);
    s_q.st == ST_IDLE && i_iack_req && cif.rsp == r;
  endsequence
  sequence s_ext_cycle;
    !o_ts_n && o_atm ##1 o_ts_n && !o_atm;
  endsequence

  a_ext_addr_drive: assert property (!o_ts_n |-> o_tt == `SIACK_EXT_TT &&
      o_addr[27:5] == `SIACK_EXT_ADDR_HI && o_addr[1:0] == 2'b00 && o_addr[4:2] == s_q.lvl)
    else $error("external acknowledge address wrong");
  a_ext_bus_seq: assert property (s_take(RSP_EXT_BUS) |=> s_ext_cycle)
    else $error("external acknowledge strobe sequence wrong");
  a_atm_with_ts: assert property (o_atm == !o_ts_n)
    else $error("attribute not tied to start strobe");
  a_spur_vector: assert property (s_take(RSP_SPUR) |=> o_iack_done &&
      o_iack_vector == `SIACK_SPUR_VEC)
    else $error("spurious vector not returned");
  a_wdt_vector: assert property (s_take(RSP_WDT) |=> o_iack_done && o_ts_n &&
      o_iack_vector == $past(s_q.wdvec))
    else $error("watchdog vector wrong");
  a_ext_auto: assert property (s_take(RSP_EXT_AUTO) |=> o_ts_n && o_iack_done &&
      o_iack_vector == `SIACK_AUTOVEC_BASE + {5'h00, $past(i_iack_level)})
    else $error("external autovector wrong");
  a_int_vec_ack: assert property (s_take(RSP_INT_VEC) |=> o_int_iack != 4'h0 &&
      o_ts_n ##1 o_iack_done && o_iack_vector == $past(i_int_vector))
    else $error("internal acknowledge wrong");
  a_int_auto_ack: assert property (s_take(RSP_INT_AUTO) |=> o_int_iack != 4'h0
      ##1 o_iack_done && o_ts_n && o_iack_vector == `SIACK_AUTOVEC_BASE + {5'h00, s_q.lvl})
    else $error("internal autovector wrong");
  a_pend_follow: assert property (##1 s_q.pend ==
      (siack_lvl_dec(~$past(i_ipl_n)) & 8'hFE))
    else $error("pending does not follow level inputs");
  a_base_guard: assert property (i_ctl_move_wr && !i_supervisor |=>
      s_q.base == $past(s_q.base))
    else $error("base pointer written outside supervisor mode");
  a_wdvec_reset: assert property (@(posedge i_ref_clk) disable iff (1'b0)
      !i_nrst |=> s_q.wdvec == `SIACK_WDVEC_RST && s_q.pinsel == 8'h00)
    else $error("reset values wrong");
  a_pin_select: assert property (##1 o_reset_out_signal_rts_pin ==
      ($past(s_q.pinsel[`SIACK_PIN_RSTSEL]) ? $past(i_uart2_rts) : $past(i_reset_out)))
    else $error("shared pin select wrong");
  a_bus_quiet: assert property (!o_bus_oe |-> o_ts_n && o_tt == 2'h0 &&
      o_addr == 28'h000_0000)
    else $error("bus driven outside external acknowledge");
  a_int_no_bus: assert property (s_take(RSP_INT_AUTO) |=> !o_bus_oe ##1 !o_bus_oe)
    else $error("internal acknowledge used the bus");
  a_ext_take: assert property (s_q.st == ST_EXT_WAIT && !i_ta_n |=> o_iack_done &&
      o_iack_vector == $past(i_data[31:24]))
    else $error("external vector not taken");
  a_wo_read: assert property (hit && !i_acc_write &&
      (off == `SIACK_OFF_WDVEC || off == `SIACK_OFF_SVC) |=> o_acc_rdata == 8'h00)
    else $error("write-only location readable");
  a_pinsel_read: assert property (hit && !i_acc_write && off == `SIACK_OFF_PINSEL |=>
      o_acc_rdata == $past(s_q.pinsel))
    else $error("pin select read wrong");
  a_pinsel_write: assert property (wr && off == `SIACK_OFF_PINSEL |=>
      o_pin_func == $past(i_acc_wdata))
    else $error("pin select write lost");
  a_wdvec_write: assert property (wr && off == `SIACK_OFF_WDVEC |=>
      s_q.wdvec == $past(i_acc_wdata))
    else $error("watchdog vector write lost");
endmodule // siack_top

// >>> dv/siack_ext_dev.sv
`timescale 1ns/100ps
module siack_ext_dev (
  input  wire logic        i_ref_clk,
  input  wire logic        i_bus_oe,
  input  wire logic        i_ts_n,
  input  wire logic [7:0]  i_vector,
  input  wire logic [3:0]  i_waits,
  output logic             o_ta_n,
  output logic [31:0]      o_data
);
  logic [3:0] wait_q;
  logic       busy_q;
  // a released bus flips every cycle so a stale vector can never pass
  initial begin
    o_ta_n = 1'b1;
    o_data = 32'h0000_0000;
    busy_q = 1'b0;
    wait_q = 4'h0;
  end
  always @(negedge i_ref_clk) begin
    if (!o_ta_n) begin
      o_ta_n <= 1'b1;
      o_data <= ~o_data;
      busy_q <= 1'b0;
    end else if (i_bus_oe && !i_ts_n) begin
      busy_q <= 1'b1;
      wait_q <= i_waits;
    end else if (busy_q && wait_q == 4'h0) begin
      o_ta_n <= 1'b0;
      o_data <= {i_vector, ~o_data[23:0]};
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule // siack_ext_dev

// >>> dv/sim_interrupt_ack_and_watchdog_regs_test.sv
`timescale 1ns/100ps
`include "siack_cfg.svh"
module sim_interrupt_ack_and_watchdog_regs_test;
  import siack_pkg::*;
  localparam logic [31:0] base_addr = 32'h1000_0000;
  logic        i_ref_clk, i_nrst, i_ctl_move_wr, i_supervisor, i_acc_valid, i_acc_write;
  logic [11:0] i_ctl_code;
  logic [31:0] i_ctl_wdata, i_acc_addr, i_data;
  logic [7:0]  i_acc_wdata, i_int_vector, o_acc_rdata, o_iack_vector, o_pin_func, ext_vec;
  logic [2:0]  i_ipl_n, i_iack_level;
  logic [3:0]  i_int_req, o_int_iack, waits, ack;
  logic        i_wdt_irq, i_iack_req, i_ta_n, i_reset_out, i_uart2_rts, o_acc_hit;
  logic        o_iack_busy, o_iack_done, o_ts_n, o_atm, o_bus_oe, o_wdt_restart;
  logic        o_reset_out_signal_rts_pin, bus, hit;
  logic [27:0] o_addr;
  logic [1:0]  o_tt;
  logic [7:0]  vec, rdv, pv;
  int          miscompares = 0, checked = 0, cycles = 0, restarts = 0;

  siack_top siack_top_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_ctl_move_wr(i_ctl_move_wr), .i_ctl_code(i_ctl_code), .i_supervisor(i_supervisor),
    .i_ctl_wdata(i_ctl_wdata), .i_acc_valid(i_acc_valid), .i_acc_write(i_acc_write),
    .i_acc_addr(i_acc_addr), .i_acc_wdata(i_acc_wdata), .o_acc_hit(o_acc_hit),
    .o_acc_rdata(o_acc_rdata), .i_ipl_n(i_ipl_n), .i_int_req(i_int_req),
    .i_int_vector(i_int_vector), .i_wdt_irq(i_wdt_irq), .i_iack_req(i_iack_req),
    .i_iack_level(i_iack_level), .o_iack_busy(o_iack_busy), .o_iack_done(o_iack_done),
    .o_iack_vector(o_iack_vector), .o_int_iack(o_int_iack), .o_addr(o_addr), .o_tt(o_tt),
    .o_ts_n(o_ts_n), .o_atm(o_atm), .o_bus_oe(o_bus_oe), .i_ta_n(i_ta_n), .i_data(i_data),
    .o_wdt_restart(o_wdt_restart), .o_pin_func(o_pin_func), .i_reset_out(i_reset_out),
    .i_uart2_rts(i_uart2_rts), .o_reset_out_signal_rts_pin(o_reset_out_signal_rts_pin));
  siack_ext_dev siack_ext_dev_inst (.i_ref_clk(i_ref_clk), .i_bus_oe(o_bus_oe),
    .i_ts_n(o_ts_n), .i_vector(ext_vec), .i_waits(waits), .o_ta_n(i_ta_n), .o_data(i_data));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [9:0] off, input logic [7:0] d,
                     output logic [7:0] q, output logic h);
    @(negedge i_ref_clk);
    i_acc_valid = 1'b1;
    i_acc_write = w;
    i_acc_addr = base_addr + {22'h00_0000, off};
    i_acc_wdata = d;
    #1 h = o_acc_hit;
    @(negedge i_ref_clk);
    q = o_acc_rdata;
    i_acc_valid = 1'b0;
  endtask

  task automatic wr(input logic [9:0] off, input logic [7:0] d);
    logic [7:0] q;
    logic h;
    acc(1'b1, off, d, q, h);
  endtask

  task automatic iack(input logic [2:0] lvl, output logic [7:0] v, output logic b,
                      output logic [3:0] a);
    b = 1'b0;
    a = 4'h0;
    @(negedge i_ref_clk);
    i_iack_req = 1'b1;
    i_iack_level = lvl;
    @(negedge i_ref_clk);
    i_iack_req = 1'b0;
    for (int n = 0; n < 40 && o_iack_done !== 1'b1; n++) begin
      b = b | o_bus_oe;
      a = a | o_int_iack;
      chk("attribute", o_atm, !o_ts_n);
      chk("ack busy", o_iack_busy, 1'b1);
      if (o_ts_n === 1'b0) begin
        chk("ack address", o_addr, {23'h7F_FFFF, lvl, 2'b00});
        chk("ack type", o_tt, 2'h3);
      end
      @(negedge i_ref_clk);
    end
    v = o_iack_vector;
    chk("ack done", o_iack_done, 1'b1);
    @(negedge i_ref_clk);
  endtask

  always @(posedge i_ref_clk) begin
    if (o_wdt_restart === 1'b1) restarts++;
    cycles++;
    // generous bound: the whole sequence needs well under a thousand cycles
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    {i_nrst, i_ctl_move_wr, i_supervisor, i_acc_valid, i_acc_write, i_wdt_irq} = '0;
    {i_iack_req, i_reset_out, i_uart2_rts, i_ctl_code, i_ctl_wdata, i_acc_addr} = '0;
    {i_acc_wdata, i_int_vector, i_iack_level, i_int_req, waits} = '0;
    i_ipl_n = 3'b111;
    ext_vec = 8'h40;
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_nrst = 1'b1;
    for (int k = 0; k < 3; k++) begin
      acc(1'b0, `SIACK_OFF_PINSEL, 8'h00, rdv, hit);
      chk("hit before base", hit, 1'b0);
      @(negedge i_ref_clk);
      i_ctl_move_wr = 1'b1;
      i_ctl_code = (k == 0) ? 12'hC0E : 12'hC0F;
      i_supervisor = (k != 1);
      i_ctl_wdata = base_addr | 32'h0000_0001;
      @(negedge i_ref_clk);
      i_ctl_move_wr = 1'b0;
    end
    acc(1'b0, `SIACK_OFF_PINSEL, 8'h00, rdv, hit);
    chk("hit after base", hit, 1'b1);
    chk("pin select reset", rdv, 8'h00);
    $display("test base pointer done");
    for (int k = 0; k < 4; k++) begin
      pv = k[1] ? 8'hA5 : 8'h5A;
      i_reset_out = k[0];
      i_uart2_rts = ~k[0];
      wr(`SIACK_OFF_PINSEL, pv);
      repeat (2) @(negedge i_ref_clk);
      chk("shared pin", o_reset_out_signal_rts_pin, pv[7] ^ k[0]);
      acc(1'b0, `SIACK_OFF_PINSEL, 8'h00, rdv, hit);
      chk("pin select read", rdv, pv);
      chk("pin function", o_pin_func, pv);
    end
    acc(1'b0, 10'h100, 8'h00, rdv, hit);
    chk("unmapped read", rdv, 8'h00);
    $display("test pin select done");
    i_wdt_irq = 1'b1;
    iack(3'd7, vec, bus, ack);
    chk("watchdog vector reset", vec, 8'h0F);
    chk("watchdog no bus", bus, 1'b0);
    wr(`SIACK_OFF_WDVEC, 8'hC3);
    iack(3'd7, vec, bus, ack);
    chk("watchdog vector", vec, 8'hC3);
    acc(1'b0, `SIACK_OFF_WDVEC, 8'h00, rdv, hit);
    chk("vector write only", rdv, 8'h00);
    i_wdt_irq = 1'b0;
    $display("test watchdog vector done");
    wr(`SIACK_OFF_SVC, 8'hAA);
    wr(`SIACK_OFF_SVC, 8'h55);
    wr(`SIACK_OFF_SVC, 8'h12);
    wr(`SIACK_OFF_SVC, 8'h55);
    acc(1'b0, `SIACK_OFF_SVC, 8'h00, rdv, hit);
    chk("service write only", rdv, 8'h00);
    repeat (3) @(negedge i_ref_clk);
    chk("restart early", restarts, 0);
    wr(`SIACK_OFF_SVC, 8'hAA);
    repeat (3) @(negedge i_ref_clk);
    chk("restart pulses", restarts, 1);
    $display("test service sequence done");
    i_ipl_n = ~3'd6;
    repeat (2) @(negedge i_ref_clk);
    acc(1'b0, `SIACK_OFF_PEND, 8'h00, rdv, hit);
    chk("pending level 6", rdv, 8'h40);
    for (int k = 0; k < 2; k++) begin
      waits = k ? 4'h3 : 4'h0;
      ext_vec = 8'h40 + k[7:0];
      iack(3'd6, vec, bus, ack);
      chk("external vector", vec, ext_vec);
      chk("external bus cycle", bus, 1'b1);
    end
    i_ipl_n = ~3'd1;
    repeat (2) @(negedge i_ref_clk);
    acc(1'b0, `SIACK_OFF_PEND, 8'h00, rdv, hit);
    chk("pending level 1", rdv, 8'h02);
    iack(3'd6, vec, bus, ack);
    chk("spurious vector", vec, 8'h18);
    chk("spurious no bus", bus, 1'b0);
    iack(3'd1, vec, bus, ack);
    chk("level 1 vector", vec, ext_vec);
    wr(`SIACK_OFF_EXTAV, 8'h02);
    iack(3'd1, vec, bus, ack);
    chk("external autovector", vec, 8'h19);
    chk("autovector no bus", bus, 1'b0);
    i_ipl_n = 3'b111;
    $display("test external acknowledge done");
    wr(`SIACK_OFF_ICR0, 8'h0D);
    wr(`SIACK_OFF_ICR0 + 10'h001, 8'h8E);
    i_int_req = 4'b0011;
    i_int_vector = 8'h77;
    iack(3'd3, vec, bus, ack);
    chk("higher priority", ack, 4'b0010);
    chk("internal autovector", vec, 8'h1B);
    chk("internal no bus", bus, 1'b0);
    wr(`SIACK_OFF_ICR0 + 10'h001, 8'h0E);
    iack(3'd3, vec, bus, ack);
    chk("peripheral vector", vec, 8'h77);
    chk("internal ack", ack, 4'b0010);
    i_int_req = 4'b0001;
    iack(3'd3, vec, bus, ack);
    chk("lower priority", ack, 4'b0001);
    $display("test internal acknowledge done");
    report_and_stop();
  end
endmodule // sim_interrupt_ack_and_watchdog_regs_test
